// File: src/pwm_channel.sv
// One PWM channel: duty buffer, compare and polarity
`timescale 1ns/10ps
`default_nettype none
module pwm_channel (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic enable_in,
	input wire logic invert_in,
	input wire logic freeze_in,
	input wire logic restart_in,
	input wire logic [9:0] new_duty_in,
	input wire logic [9:0] time_base_in,
	output logic level_out
);

	logic [9:0] duty_buf_reg;
	logic raw_reg;
	logic raw_next;
	logic level_reg;

	// Next raw waveform level
	always_comb begin
		raw_next = raw_reg;
		if (freeze_in) begin
			raw_next = raw_reg;
		end else if (!enable_in) begin
			raw_next = 1'b0;
		end else if (restart_in) begin
			raw_next = (new_duty_in != pwm_pkg::DUTY_ZERO);
		end else if (time_base_in == duty_buf_reg) begin
			raw_next = 1'b0;
		end
	end

	// Duty buffer loads only at the period restart
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			duty_buf_reg <= pwm_pkg::DUTY_BUF_RST;
		end else if (!freeze_in && enable_in && restart_in) begin
			duty_buf_reg <= new_duty_in;
		end
	end

	// Raw waveform; a duty beyond the period never matches so the level holds
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			raw_reg <= pwm_pkg::LEVEL_RST;
		end else begin
			raw_reg <= raw_next;
		end
	end

	// Output after polarity, held while frozen
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_reg <= pwm_pkg::LEVEL_RST;
		end else if (!freeze_in) begin
			level_reg <= raw_next ^ invert_in;
		end
	end

	assign level_out = level_reg;

endmodule
`default_nettype wire

// File: src/pwm_pkg.sv
// Constants and types shared by the two-channel PWM block
package pwm_pkg;

	// Bus geometry
	localparam int ADR_W = 14;
	localparam int DAT_W = 32;
	localparam int IDX_W = 12;
	localparam int SEL_W = 4;

	// Channel and time base geometry
	localparam int NUM_CH = 2;
	localparam int COUNT_W = 8;
	localparam int FRAC_W = 2;
	localparam int DUTY_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [11:0] CH_B_DUTY_IDX = 12'hFA0;
	localparam logic [11:0] CH_B_CTRL_IDX = 12'hFA2;
	localparam logic [11:0] CH_A_DUTY_IDX = 12'hFA3;
	localparam logic [11:0] CH_A_CTRL_IDX = 12'hFA5;

	// Per-channel lookup, entry 0 is channel A and entry 1 is channel B
	localparam logic [11:0] DUTY_IDX [0:1] = '{CH_A_DUTY_IDX, CH_B_DUTY_IDX};
	localparam logic [11:0] CTRL_IDX [0:1] = '{CH_A_CTRL_IDX, CH_B_CTRL_IDX};

	// Control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_POL_BIT = 4;

	// Duty register fields
	localparam int DUTY_HI_LSB = 8;
	localparam int DUTY_HI_MSB = 15;
	localparam int DUTY_LO_LSB = 6;
	localparam int DUTY_LO_MSB = 7;

	// Byte lanes
	localparam int LANE_LO = 0;
	localparam int LANE_HI = 1;

	// Values after reset
	localparam logic EN_RST = 1'b0;
	localparam logic POL_RST = 1'b0;
	localparam logic LEVEL_RST = 1'b0;
	localparam logic [7:0] DUTY_HI_RST = 8'h00;
	localparam logic [1:0] DUTY_LO_RST = 2'h0;
	localparam logic [9:0] DUTY_BUF_RST = 10'h000;
	localparam logic [1:0] FRAC_RST = 2'h0;
	localparam logic [31:0] DAT_RST = 32'h0000_0000;

	// Last value of the two low time base bits before the timer steps
	localparam logic [1:0] FRAC_LAST = 2'h3;
	localparam logic [1:0] FRAC_STEP = 2'h1;
	localparam logic [9:0] DUTY_ZERO = 10'h000;
	localparam logic [9:0] TIME_STEP = 10'h001;
	localparam logic [9:0] TIME_BASE_RST = 10'h000;

	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;

endpackage

// File: src/ten_bit_pwm_channels.sv
// Two 10-bit PWM channels on a shared period timer, with a Wishbone register slave
//
// What this block does
// - Polarity bit set inverts channel output.
// - Period is (limit+1) times 4 times prescale.
// - Limit match restarts: clear, set active, latch duty.
// - Zero duty keeps output inactive at restart.
// - Timer postscaler has no effect on waveform.
// - Duty is high byte plus low bits 7:6.
// - Duty writes anytime; buffer changes only at restart.
// - Compare duty against 10-bit extended time base.
// - At 1:1 prescale low bits step each clock.
// - Resolution is log2 of 4 times (limit+1).
// - Duty beyond period leaves output level unchanged.
// - Sleep freezes count, state and output level.
// - Reset restores registers; pins back to input.
// - Output frequency follows the system clock.
// - Output goes inactive when time base equals duty.
// - Enable bit 7 turns channel on or off.
// - Bit 5 reads back the current output level.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module ten_bit_pwm_channels (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [13:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic [7:0] BASE_COUNTER_IN,
	input wire logic [7:0] PERIOD_LIMIT_IN,
	input wire logic PRESCALE_TICK_IN,
	input wire logic SLEEP_IN,
	output logic PWM_A_OUT,
	output logic PWM_B_OUT,
	output logic PWM_A_PIN_OE_OUT,
	output logic PWM_B_PIN_OE_OUT
);

	// Bus slave state
	pwm_pkg::bus_state_t bus_state_reg;
	pwm_pkg::bus_state_t bus_state_next;
	logic [31:0] rd_data_reg;
	logic [31:0] rd_data_next;
	logic [11:0] reg_idx;
	logic bus_req;
	logic wr_commit;

	// Time base state
	logic [1:0] frac_reg;
	logic frac_step;
	logic period_restart;
	logic [9:0] time_base;
	logic [9:0] time_base_next;

	// Per-channel registers and status
	logic en_reg [0:1];
	logic pol_reg [0:1];
	logic [7:0] duty_hi_reg [0:1];
	logic [1:0] duty_lo_reg [0:1];
	logic level [0:1];

	// Pin direction follows the enable, so reset leaves the pins as inputs
	logic pin_oe_reg [0:1];

	assign reg_idx = WB_ADR_IN[13:2];
	assign bus_req = WB_CYC_IN && WB_STB_IN;
	assign wr_commit = (bus_state_reg == pwm_pkg::BUS_ACK) && bus_req && WB_WE_IN;

	// Bus handshake: answer one cycle after the request, then drop ack
	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			pwm_pkg::BUS_IDLE: begin
				if (bus_req) begin
					bus_state_next = pwm_pkg::BUS_ACK;
				end
			end
			pwm_pkg::BUS_ACK: begin
				bus_state_next = pwm_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = pwm_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			bus_state_reg <= pwm_pkg::BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	assign WB_ACK_OUT = (bus_state_reg == pwm_pkg::BUS_ACK);

	// Read mux; unmapped indices and reserved bits read as zero
	always_comb begin
		rd_data_next = pwm_pkg::DAT_RST;
		case (reg_idx)
			pwm_pkg::CH_A_DUTY_IDX: begin
				rd_data_next[pwm_pkg::DUTY_HI_MSB:pwm_pkg::DUTY_HI_LSB] = duty_hi_reg[0];
				rd_data_next[pwm_pkg::DUTY_LO_MSB:pwm_pkg::DUTY_LO_LSB] = duty_lo_reg[0];
			end
			pwm_pkg::CH_B_DUTY_IDX: begin
				rd_data_next[pwm_pkg::DUTY_HI_MSB:pwm_pkg::DUTY_HI_LSB] = duty_hi_reg[1];
				rd_data_next[pwm_pkg::DUTY_LO_MSB:pwm_pkg::DUTY_LO_LSB] = duty_lo_reg[1];
			end
			pwm_pkg::CH_A_CTRL_IDX: begin
				rd_data_next[pwm_pkg::CTRL_EN_BIT] = en_reg[0];
				rd_data_next[pwm_pkg::CTRL_OUT_BIT] = level[0];
				rd_data_next[pwm_pkg::CTRL_POL_BIT] = pol_reg[0];
			end
			pwm_pkg::CH_B_CTRL_IDX: begin
				rd_data_next[pwm_pkg::CTRL_EN_BIT] = en_reg[1];
				rd_data_next[pwm_pkg::CTRL_OUT_BIT] = level[1];
				rd_data_next[pwm_pkg::CTRL_POL_BIT] = pol_reg[1];
			end
			default: begin
				rd_data_next = pwm_pkg::DAT_RST;
			end
		endcase
	end

	// Read data captured as the request is taken and held with ack
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rd_data_reg <= pwm_pkg::DAT_RST;
		end else if (bus_state_reg == pwm_pkg::BUS_IDLE && bus_req && !WB_WE_IN) begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign WB_DAT_OUT = rd_data_reg;

	// Two low time base bits, stepped by the prescaler phase
	assign frac_step = PRESCALE_TICK_IN && !SLEEP_IN;
	assign time_base = {BASE_COUNTER_IN, frac_reg};

	// Restart on the increment that wraps the low bits while the count equals the limit
	assign period_restart = frac_step && (frac_reg == pwm_pkg::FRAC_LAST)
		&& (BASE_COUNTER_IN == PERIOD_LIMIT_IN);

	// Time base as it stands after this edge, so the output drops as the count lands on duty
	always_comb begin
		time_base_next = time_base;
		if (period_restart) begin
			time_base_next = pwm_pkg::TIME_BASE_RST;
		end else if (frac_step) begin
			time_base_next = time_base + pwm_pkg::TIME_STEP;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			frac_reg <= pwm_pkg::FRAC_RST;
		end else if (frac_step) begin
			frac_reg <= frac_reg + pwm_pkg::FRAC_STEP;
		end
	end

	// Per-channel registers, buffer and waveform
	genvar ch;
	generate
		for (ch = 0; ch < pwm_pkg::NUM_CH; ch = ch + 1) begin : g_ch
			logic duty_hit;
			logic ctrl_hit;

			assign duty_hit = wr_commit && (reg_idx == pwm_pkg::DUTY_IDX[ch]);
			assign ctrl_hit = wr_commit && (reg_idx == pwm_pkg::CTRL_IDX[ch]);

			// Duty high byte, written at any time
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					duty_hi_reg[ch] <= pwm_pkg::DUTY_HI_RST;
				end else if (duty_hit && WB_SEL_IN[pwm_pkg::LANE_HI]) begin
					duty_hi_reg[ch] <= WB_DAT_IN[pwm_pkg::DUTY_HI_MSB:pwm_pkg::DUTY_HI_LSB];
				end
			end

			// Duty low bits, only bits 7:6 are kept
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					duty_lo_reg[ch] <= pwm_pkg::DUTY_LO_RST;
				end else if (duty_hit && WB_SEL_IN[pwm_pkg::LANE_LO]) begin
					duty_lo_reg[ch] <= WB_DAT_IN[pwm_pkg::DUTY_LO_MSB:pwm_pkg::DUTY_LO_LSB];
				end
			end

			// Enable and polarity; the level bit is read-only
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					en_reg[ch] <= pwm_pkg::EN_RST;
					pol_reg[ch] <= pwm_pkg::POL_RST;
				end else if (ctrl_hit && WB_SEL_IN[pwm_pkg::LANE_LO]) begin
					en_reg[ch] <= WB_DAT_IN[pwm_pkg::CTRL_EN_BIT];
					pol_reg[ch] <= WB_DAT_IN[pwm_pkg::CTRL_POL_BIT];
				end
			end

			// Pin drive request tracks the enable; input direction after reset
			always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					pin_oe_reg[ch] <= 1'b0;
				end else begin
					pin_oe_reg[ch] <= en_reg[ch];
				end
			end

			pwm_channel u_channel (
				.clk_in(CLK_IN),
				.resetn_in(RESETN_IN),
				.enable_in(en_reg[ch]),
				.invert_in(pol_reg[ch]),
				.freeze_in(SLEEP_IN),
				.restart_in(period_restart),
				.new_duty_in({duty_hi_reg[ch], duty_lo_reg[ch]}),
				.time_base_in(time_base_next),
				.level_out(level[ch])
			);
		end
	endgenerate

	assign PWM_A_OUT = level[0];
	assign PWM_B_OUT = level[1];
	assign PWM_A_PIN_OE_OUT = pin_oe_reg[0];
	assign PWM_B_PIN_OE_OUT = pin_oe_reg[1];

endmodule
`default_nettype wire

// File: tb/pwm_timer_model.sv
// Period timer model that feeds the shared base count
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic tick_in,
	input wire logic sleep_in,
	input wire logic [7:0] limit_in,
	output logic [7:0] count_out
);
	logic [1:0] frac_reg;
	// Steps the count each time the low bits wrap
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			frac_reg <= 2'h0;
			count_out <= 8'h00;
		end else if (tick_in && !sleep_in) begin
			frac_reg <= frac_reg + 2'h1;
			if (frac_reg == 2'h3) begin
				count_out <= (count_out == limit_in) ? 8'h00 : count_out + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the two-channel PWM block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk, rstn, cyc, stb, we, tick, sleep, div, ack, pa, pb, oea, oeb;
	logic [13:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd, ca, cb;
	logic [7:0] cnt;
	int miscompares, checked, cycles;
	ten_bit_pwm_channels i_dut (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .BASE_COUNTER_IN(cnt), .PERIOD_LIMIT_IN(8'h03),
		.PRESCALE_TICK_IN(tick), .SLEEP_IN(sleep), .PWM_A_OUT(pa), .PWM_B_OUT(pb),
		.PWM_A_PIN_OE_OUT(oea), .PWM_B_PIN_OE_OUT(oeb));
	pwm_timer_model i_tmr (.clk_in(clk), .resetn_in(rstn), .tick_in(tick), .sleep_in(sleep),
		.limit_in(8'h03), .count_out(cnt));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		tick <= div ? ~tick : 1'b1;
		cycles <= cycles + 1;
		if (cycles > 3000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		sel <= 4'h3;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		if (n >= 50) begin
			miscompares++;
			print_verdict();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic count_high(input int n);
		ca = 32'h0;
		cb = 32'h0;
		repeat (n) begin
			@(posedge clk);
			ca = ca + {31'h0, pa};
			cb = cb + {31'h0, pb};
		end
	endtask
	task automatic t_reset();
		logic [11:0] ix [5];
		ix = '{pwm_pkg::CH_A_DUTY_IDX, pwm_pkg::CH_A_CTRL_IDX, pwm_pkg::CH_B_DUTY_IDX,
			pwm_pkg::CH_B_CTRL_IDX, 12'h001};
		wb(1'b1, 12'h001, 32'hFFFF_FFFF);
		foreach (ix[i]) begin
			wb(1'b0, ix[i], 32'h0);
			check(rd, 32'h0000_0000);
		end
		check({28'h0, oea, oeb, pa, pb}, 32'h0000_0000);
	endtask
	task automatic t_idle_pol();
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0010);
		repeat (3) @(posedge clk);
		check({31'h0, pa}, 32'h0000_0001);
		wb(1'b0, pwm_pkg::CH_A_CTRL_IDX, 32'h0);
		check(rd, 32'h0000_0030);
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0000);
	endtask
	task automatic t_wave();
		wb(1'b1, pwm_pkg::CH_A_DUTY_IDX, 32'h0000_0140);
		wb(1'b0, pwm_pkg::CH_A_DUTY_IDX, 32'h0);
		check(rd, 32'h0000_0140);
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0080);
		wb(1'b1, pwm_pkg::CH_B_CTRL_IDX, 32'h0000_0080);
		repeat (40) @(posedge clk);
		count_high(32);
		check(ca, 32'd10);
		check(cb, 32'd0);
		check({30'h0, oea, oeb}, 32'h0000_0003);
		wb(1'b1, pwm_pkg::CH_B_DUTY_IDX, 32'h0000_0500);
		wb(1'b1, pwm_pkg::CH_A_DUTY_IDX, 32'h0000_03C0);
		repeat (40) @(posedge clk);
		count_high(32);
		check(ca, 32'd30);
		check(cb, 32'd32);
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0090);
		repeat (40) @(posedge clk);
		count_high(32);
		check(ca, 32'd2);
	endtask
	task automatic t_prescale_sleep();
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0080);
		wb(1'b1, pwm_pkg::CH_A_DUTY_IDX, 32'h0000_0140);
		div <= 1'b1;
		repeat (80) @(posedge clk);
		count_high(64);
		check(ca, 32'd20);
		sleep <= 1'b1;
		count_high(40);
		check(ca, pa ? 32'd40 : 32'd0);
		sleep <= 1'b0;
		count_high(64);
		check(ca, 32'd20);
		check(cb, 32'd64);
		wb(1'b1, pwm_pkg::CH_A_CTRL_IDX, 32'h0000_0000);
		count_high(64);
		check(ca, 32'd0);
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		{rstn, cyc, stb, we, sleep, div} = 6'h00;
		tick = 1'b1;
		adr = 14'h0000;
		sel = 4'h3;
		wdat = 32'h0000_0000;
		{miscompares, checked, cycles} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_idle_pol();
		t_wave();
		t_prescale_sleep();
		print_verdict();
	end
endmodule
`default_nettype wire

// File: tb/ten_bit_pwm_channels_asserts.sv
// Bus and output timing checks for the PWM block
`timescale 1ns/10ps
`default_nettype none
module ten_bit_pwm_channels_asserts (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic SLEEP_IN,
	input wire logic PWM_A_OUT,
	input wire logic PWM_B_OUT,
	input wire logic PWM_A_PIN_OE_OUT,
	input wire logic PWM_B_PIN_OE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	chk_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held too long");
	chk_ack_next_cycle: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT)
		else $error("ack not one cycle after request");
	chk_no_stray_ack: assert property (!(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT)
		else $error("ack without request");
	chk_reset_quiet: assert property ($rose(RESETN_IN) |-> (WB_DAT_OUT == 32'h0000_0000) &&
		!PWM_A_OUT && !PWM_B_OUT && !PWM_A_PIN_OE_OUT && !PWM_B_PIN_OE_OUT)
		else $error("outputs not cleared by reset");
	chk_read_data_holds: assert property (WB_ACK_OUT |=> $stable(WB_DAT_OUT))
		else $error("read data changed after ack");
	chk_sleep_freeze: assert property ((SLEEP_IN && $past(SLEEP_IN)) |=> $stable({PWM_A_OUT, PWM_B_OUT}))
		else $error("output moved in sleep");
	chk_oe_a_after_write: assert property ($changed(PWM_A_PIN_OE_OUT) |-> $past(WB_ACK_OUT && WB_WE_IN, 2))
		else $error("pin enable A changed without write");
	chk_oe_b_after_write: assert property ($changed(PWM_B_PIN_OE_OUT) |-> $past(WB_ACK_OUT && WB_WE_IN, 2))
		else $error("pin enable B changed without write");
endmodule
bind ten_bit_pwm_channels ten_bit_pwm_channels_asserts i_chk (.CLK_IN, .RESETN_IN, .WB_CYC_IN,
	.WB_STB_IN, .WB_WE_IN, .WB_DAT_OUT, .WB_ACK_OUT, .SLEEP_IN, .PWM_A_OUT, .PWM_B_OUT,
	.PWM_A_PIN_OE_OUT, .PWM_B_PIN_OE_OUT);
`default_nettype wire
